// >>> include/gss_defines.vh
// How it works
// - output pulses scale by numerator over denominator
// - 17-bit 32768, 20-bit 262144 pulses per revolution
// - one reference pulse moves one reference unit
// - preset speeds only for methods 3 to 6
// - otherwise P/PI and torque limit enables
// - select pattern picks speed one two three
// - both off: stop or fallback per method
// - direction input off forward, on reverse
// - contact inputs are active low
// - allocation mode 0 remaps inputs automatically
// - functions only usable when allocated
// - three preset speeds, 0 to 10000 rpm; registers accept any 16-bit value
// - clamp preset speed to motor maximum
// - select inputs may lag up to 2 ms
`ifndef GSS_DEFINES_VH
`define GSS_DEFINES_VH
`define GSS_OFF_METHOD    5'h00
`define GSS_OFF_NUM       5'h04
`define GSS_OFF_DEN       5'h08
`define GSS_OFF_SPD1      5'h0c
`define GSS_OFF_SPD2      5'h10
`define GSS_OFF_SPD3      5'h14
`define GSS_OFF_CFG       5'h18
`define GSS_OFF_STATUS    5'h1c
`define GSS_RST_METHOD    4'h0
`define GSS_RST_NUM       16'h0004
`define GSS_RST_DEN       16'h0001
`define GSS_RST_SPD1      16'h0064
`define GSS_RST_SPD2      16'h00c8
`define GSS_RST_SPD3      16'h012c
`define GSS_RST_ALLOC     4'h0
`define GSS_SPEED_MAX     16'h2710
`define GSS_ENC_PPR_17    32'h00008000
`define GSS_ENC_PPR_20    32'h00040000
`define GSS_SAMPLE_US     2000
`define GSS_CLK_MHZ       20
`define GSS_SAMPLE_CYC    (`GSS_SAMPLE_US * `GSS_CLK_MHZ)
// cfg register fields
`define GSS_CFG_ALLOC_LSB 0
`define GSS_CFG_MAP_BIT   4
`define GSS_CFG_ENC20_BIT 5
`define GSS_CFG_MAXS_LSB  16
`endif

// >>> verilog/gss_gear_scaler.v
`timescale 1ns/10ps
`include "gss_defines.vh"
module gss_gear_scaler #(
	parameter W = 16
) (
	// clock and reset
	input  wire         i_clk,
	input  wire         i_srst,
	// ratio and pulse in
	input  wire [W-1:0] i_num,
	input  wire [W-1:0] i_den,
	input  wire         i_pulse,
	// scaled pulse out
	output reg          o_pulse,
	output wire         o_busy
);
	reg [W:0]   acc_reg;
	reg [W-1:0] left_reg;
	// remainder kept between pulses so fraction is never lost
	wire [W:0]  sum = acc_reg + {1'b0, i_num};
	wire [W-1:0] den = (i_den == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : i_den;
	assign o_busy = (left_reg != {W{1'b0}});
	// emits floor((acc+num)/den) pulses, one per cycle
	always @(posedge i_clk) begin
		if (i_srst) begin
			acc_reg  <= {(W+1){1'b0}};
			left_reg <= {W{1'b0}};
			o_pulse  <= 1'b0;
		end else begin
			o_pulse <= 1'b0;
			if (left_reg != {W{1'b0}}) begin
				// step only on a whole denominator, else stop and keep the rest
				if (acc_reg >= {1'b0, den}) begin
					o_pulse <= 1'b1;
					acc_reg <= acc_reg - {1'b0, den};
				end else begin
					left_reg <= {W{1'b0}};
				end
			end else if (i_pulse) begin
				acc_reg  <= sum;
				left_reg <= {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// >>> verilog/gss_top.v
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "gss_defines.vh"
module gss_top #(
	parameter SAMPLE_CYC = `GSS_SAMPLE_CYC
) (
	// clock and reset
	input  wire        i_clk,
	input  wire        i_srst,
	// axi4-lite write address
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// host pins, contacts active low
	input  wire        i_ref_pulse,
	input  wire        i_rotation_direction_select_n,
	input  wire        i_fwd_limit_or_select_a_input_n,
	input  wire        i_rev_limit_or_select_b_input_n,
	// motor side outputs
	output reg         o_motor_step,
	output reg  [15:0] o_speed_ref,
	output reg         o_speed_reverse,
	output reg         o_preset_active,
	output reg  [1:0]  o_fallback_mode,
	output reg         o_pi_to_p,
	output reg         o_fwd_tlim_en,
	output reg         o_rev_tlim_en
);
	localparam [1:0] FB_ZERO = 2'h0, FB_ANALOG_SPD = 2'h1, FB_PULSE = 2'h2, FB_TORQUE = 2'h3;
	localparam [15:0] SCYC = SAMPLE_CYC[15:0];

	// registers
	reg [3:0]  control_method_select_reg;
	reg [15:0] gear_ratio_numerator_reg;
	reg [15:0] gear_ratio_denominator_reg;
	reg [15:0] preset_speed_one_reg;
	reg [15:0] preset_speed_two_reg;
	reg [15:0] preset_speed_three_reg;
	reg [3:0]  input_allocation_mode_reg;
	reg        manual_map_reg;
	reg        enc20_reg;
	reg [15:0] motor_max_reg;

	// pin synchronisers, two flops each
	reg [3:0] s1_reg;
	reg [3:0] s2_reg;
	always @(posedge i_clk) begin
		if (i_srst) begin
			// pulse idles low, contacts idle high: no false edge after reset
			s1_reg <= 4'h7;
			s2_reg <= 4'h7;
		end else begin
			s1_reg <= {i_ref_pulse, i_rotation_direction_select_n,
				i_fwd_limit_or_select_a_input_n, i_rev_limit_or_select_b_input_n};
			s2_reg <= s1_reg;
		end
	end
	// contacts are on when low
	wire dir_on = ~s2_reg[2];
	wire a_on   = ~s2_reg[1];
	wire b_on   = ~s2_reg[0];

	// reference pulse edge
	reg pulse_d_reg;
	always @(posedge i_clk) begin
		if (i_srst)
			pulse_d_reg <= 1'b0;
		else
			pulse_d_reg <= s2_reg[3];
	end
	wire pulse_rise = s2_reg[3] & ~pulse_d_reg;

	// gear scaler; pulses arriving while busy are dropped, host must pace them
	wire step_w;
	gss_gear_scaler #(.W(16)) u_gear (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_num   (gear_ratio_numerator_reg),
		.i_den   (gear_ratio_denominator_reg),
		.i_pulse (pulse_rise),
		.o_pulse (step_w),
		.o_busy  ()
	);

	// select inputs sampled on a slow tick, latency up to 2 ms tolerated
	reg [15:0] tick_cnt_reg;
	reg        sa_reg;
	reg        sb_reg;
	always @(posedge i_clk) begin
		if (i_srst) begin
			tick_cnt_reg <= 16'h0000;
			sa_reg       <= 1'b0;
			sb_reg       <= 1'b0;
		end else if (tick_cnt_reg >= SCYC - 16'h0001) begin
			tick_cnt_reg <= 16'h0000;
			sa_reg       <= a_on;
			sb_reg       <= b_on;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
		end
	end

	// mode decode
	wire method_preset = (control_method_select_reg >= 4'h3) &&
		(control_method_select_reg <= 4'h6);
	// automatic remap with mode 0, else only if software allocated the inputs
	wire mapped = (input_allocation_mode_reg == 4'h0) | manual_map_reg;
	wire preset = method_preset & mapped;

	// speed selection and clamp
	reg [15:0] sel_spd;
	reg [15:0] lim_spd;
	always @* begin
		case ({sa_reg, sb_reg})
			2'b01:   sel_spd = preset_speed_one_reg;
			2'b11:   sel_spd = preset_speed_two_reg;
			2'b10:   sel_spd = preset_speed_three_reg;
			default: sel_spd = 16'h0000;
		endcase
		lim_spd = (sel_spd > motor_max_reg) ? motor_max_reg : sel_spd;
	end

	// registered motor side outputs
	always @(posedge i_clk) begin
		if (i_srst) begin
			o_motor_step    <= 1'b0;
			o_speed_ref     <= 16'h0000;
			o_speed_reverse <= 1'b0;
			o_preset_active <= 1'b0;
			o_fallback_mode <= FB_ZERO;
			o_pi_to_p       <= 1'b0;
			o_fwd_tlim_en   <= 1'b0;
			o_rev_tlim_en   <= 1'b0;
		end else begin
			o_motor_step    <= step_w;
			o_preset_active <= preset & (sa_reg | sb_reg);
			if (preset) begin
				o_speed_ref     <= lim_spd;
				o_speed_reverse <= dir_on;
				o_pi_to_p       <= 1'b0;
				o_fwd_tlim_en   <= 1'b0;
				o_rev_tlim_en   <= 1'b0;
				case (control_method_select_reg)
					4'h4:    o_fallback_mode <= FB_ANALOG_SPD;
					4'h5:    o_fallback_mode <= FB_PULSE;
					4'h6:    o_fallback_mode <= FB_TORQUE;
					default: o_fallback_mode <= FB_ZERO;
				endcase
			end else begin
				o_speed_ref     <= 16'h0000;
				o_speed_reverse <= 1'b0;
				o_fallback_mode <= FB_ZERO;
				o_pi_to_p       <= dir_on;
				o_fwd_tlim_en   <= a_on;
				o_rev_tlim_en   <= b_on;
			end
		end
	end

	// axi write path: address and data latched in either order
	reg        aw_have_reg;
	reg        w_have_reg;
	reg [4:0]  aw_reg;
	reg [31:0] wd_reg;
	reg [3:0]  ws_reg;
	wire       do_wr = aw_have_reg & w_have_reg & ~s_axi_bvalid;
	wire [31:0] wm = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
	always @(posedge i_clk) begin
		if (i_srst) begin
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			aw_reg        <= 5'h00;
			wd_reg        <= 32'h00000000;
			ws_reg        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= ~aw_have_reg & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~w_have_reg & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_reg      <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_reg <= 1'b1;
				wd_reg     <= s_axi_wdata;
				ws_reg     <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_reg[1:0] == 2'h0) ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register writes, byte lanes honoured; zero divisor is ignored
	wire [31:0] nv_num = ({16'h0000, gear_ratio_numerator_reg} & ~wm) | (wd_reg & wm);
	wire [31:0] nv_den = ({16'h0000, gear_ratio_denominator_reg} & ~wm) | (wd_reg & wm);
	always @(posedge i_clk) begin
		if (i_srst) begin
			control_method_select_reg  <= `GSS_RST_METHOD;
			gear_ratio_numerator_reg   <= `GSS_RST_NUM;
			gear_ratio_denominator_reg <= `GSS_RST_DEN;
			preset_speed_one_reg       <= `GSS_RST_SPD1;
			preset_speed_two_reg       <= `GSS_RST_SPD2;
			preset_speed_three_reg     <= `GSS_RST_SPD3;
			input_allocation_mode_reg  <= `GSS_RST_ALLOC;
			manual_map_reg             <= 1'b0;
			enc20_reg                  <= 1'b0;
			motor_max_reg              <= `GSS_SPEED_MAX;
		end else if (do_wr) begin
			case (aw_reg)
				`GSS_OFF_METHOD: if (ws_reg[0]) control_method_select_reg <= wd_reg[3:0];
				`GSS_OFF_NUM: if (nv_num[15:0] != 16'h0000)
					gear_ratio_numerator_reg <= nv_num[15:0];
				`GSS_OFF_DEN: if (nv_den[15:0] != 16'h0000)
					gear_ratio_denominator_reg <= nv_den[15:0];
				`GSS_OFF_SPD1: preset_speed_one_reg <= (preset_speed_one_reg & ~wm[15:0])
					| (wd_reg[15:0] & wm[15:0]);
				`GSS_OFF_SPD2: preset_speed_two_reg <= (preset_speed_two_reg & ~wm[15:0])
					| (wd_reg[15:0] & wm[15:0]);
				`GSS_OFF_SPD3: preset_speed_three_reg <= (preset_speed_three_reg & ~wm[15:0])
					| (wd_reg[15:0] & wm[15:0]);
				`GSS_OFF_CFG: begin
					if (ws_reg[0]) begin
						input_allocation_mode_reg <= wd_reg[`GSS_CFG_ALLOC_LSB +: 4];
						manual_map_reg            <= wd_reg[`GSS_CFG_MAP_BIT];
						enc20_reg                 <= wd_reg[`GSS_CFG_ENC20_BIT];
					end
					if (ws_reg[3] & ws_reg[2])
						motor_max_reg <= wd_reg[`GSS_CFG_MAXS_LSB +: 16];
				end
				default: ;
			endcase
		end
	end

	// axi read path, one cycle after address taken
	always @(posedge i_clk) begin
		if (i_srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				case (s_axi_araddr)
					`GSS_OFF_METHOD: s_axi_rdata <= {28'h0000000, control_method_select_reg};
					`GSS_OFF_NUM:    s_axi_rdata <= {16'h0000, gear_ratio_numerator_reg};
					`GSS_OFF_DEN:    s_axi_rdata <= {16'h0000, gear_ratio_denominator_reg};
					`GSS_OFF_SPD1:   s_axi_rdata <= {16'h0000, preset_speed_one_reg};
					`GSS_OFF_SPD2:   s_axi_rdata <= {16'h0000, preset_speed_two_reg};
					`GSS_OFF_SPD3:   s_axi_rdata <= {16'h0000, preset_speed_three_reg};
					`GSS_OFF_CFG:    s_axi_rdata <= {motor_max_reg, 10'h000, enc20_reg,
						manual_map_reg, input_allocation_mode_reg};
					`GSS_OFF_STATUS: s_axi_rdata <= {16'h0000, o_speed_ref[7:0],
						1'b0, o_fallback_mode, o_preset_active, o_speed_reverse,
						dir_on, sa_reg, sb_reg};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// >>> testbench/gss_top_properties.sv
`timescale 1ns/10ps
module gss_top_properties (
	// clock and reset
	input wire        i_clk,
	input wire        i_srst,
	// bus handshakes
	input wire        s_axi_awready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	// contacts and motor side
	input wire        i_rotation_direction_select_n,
	input wire [15:0] o_speed_ref,
	input wire        o_speed_reverse,
	input wire        o_preset_active,
	input wire        o_pi_to_p,
	input wire        o_fwd_tlim_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// read taken, then data held until the master takes it
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rd_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	ar_ready_a: assert property (s_axi_arready |-> s_axi_arvalid)
		else $error("arready without request");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	// sync chain plus register gives three cycles
	dir_lag_a: assert property (o_pi_to_p |-> !$past(i_rotation_direction_select_n, 3))
		else $error("p control without contact");
	mode_excl_a: assert property (!(o_speed_reverse && o_pi_to_p))
		else $error("direction and p control together");
	tlim_off_a: assert property (o_preset_active |-> !o_fwd_tlim_en)
		else $error("torque limit in preset mode");
	speed_src_a: assert property (o_speed_ref != 16'h0 |-> o_preset_active)
		else $error("speed without preset");
endmodule
bind gss_top gss_top_properties chk_u (
	.i_clk, .i_srst, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.i_rotation_direction_select_n, .o_speed_ref, .o_speed_reverse, .o_preset_active,
	.o_pi_to_p, .o_fwd_tlim_en
);

// >>> testbench/gss_host_model.sv
`timescale 1ns/10ps
module gss_host_model (
	// clock
	input  wire i_clk,
	// pulse and contacts to the device
	output reg  o_ref_pulse,
	output reg  o_dir_n,
	output reg  o_sel_a_n,
	output reg  o_sel_b_n
);
	// contacts open, pins at high level
	initial begin
		o_ref_pulse = 1'b0;
		o_dir_n = 1'b1;
		o_sel_a_n = 1'b1;
		o_sel_b_n = 1'b1;
	end
	// on means pulled low
	task set_contacts(input logic d, input logic a, input logic b);
		@(posedge i_clk);
		o_dir_n <= ~d;
		o_sel_a_n <= ~a;
		o_sel_b_n <= ~b;
	endtask
	// gap must outlast the step burst, else pulses are dropped
	task send_pulses(input int n, input int gap);
		repeat (n) begin
			@(posedge i_clk);
			o_ref_pulse <= 1'b1;
			repeat (4) @(posedge i_clk);
			o_ref_pulse <= 1'b0;
			repeat (gap) @(posedge i_clk);
		end
	endtask
endmodule

// >>> testbench/gss_top_bench.sv
`timescale 1ns/10ps
module gss_top_bench;
	reg        i_clk, i_srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	reg        s_axi_arvalid, s_axi_rready;
	reg [4:0]  s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata, rd;
	reg [1:0]  rs, ws;
	wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, o_fallback_mode;
	wire [31:0] s_axi_rdata;
	wire [15:0] o_speed_ref;
	wire       i_ref_pulse, i_rotation_direction_select_n, i_fwd_limit_or_select_a_input_n;
	wire       i_rev_limit_or_select_b_input_n, o_motor_step, o_speed_reverse;
	wire       o_preset_active, o_pi_to_p, o_fwd_tlim_en, o_rev_tlim_en;
	integer    failures, compares, steps, cyc, i;
	logic [31:0] defs [0:5] = '{32'h0, 32'h4, 32'h1, 32'h64, 32'hc8, 32'h12c};
	logic [31:0] gear [0:2] = '{32'h03020406, 32'h02030302, 32'h01010505};
	logic [31:0] cs [0:4] = '{32'h06060000, 32'h71010000, 32'h31100064, 32'h471800c8,
		32'h52102710};
	gss_top #(.SAMPLE_CYC(8)) dut_u (
		.i_clk, .i_srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_ref_pulse,
		.i_rotation_direction_select_n, .i_fwd_limit_or_select_a_input_n,
		.i_rev_limit_or_select_b_input_n, .o_motor_step, .o_speed_ref, .o_speed_reverse,
		.o_preset_active, .o_fallback_mode, .o_pi_to_p, .o_fwd_tlim_en, .o_rev_tlim_en
	);
	gss_host_model host_u (
		.i_clk,
		.o_ref_pulse(i_ref_pulse),
		.o_dir_n(i_rotation_direction_select_n),
		.o_sel_a_n(i_fwd_limit_or_select_a_input_n),
		.o_sel_b_n(i_rev_limit_or_select_b_input_n)
	);
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// step count and hang guard
	always @(posedge i_clk) begin
		if (o_motor_step === 1'b1)
			steps <= steps + 1;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			failures = failures + 1;
			give_verdict;
		end
	end
	task check(input [8*8-1:0] name, input [31:0] exp, input [31:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("[ERR] %0s exp %h got %h", name, exp, got);
		end
	endtask
	task axi_wr(input [4:0] a, input [31:0] d);
		@(posedge i_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		ws = s_axi_bresp;
	endtask
	task axi_rd(input [4:0] a);
		@(posedge i_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge i_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rs = s_axi_rresp;
	endtask
	// A/B resample every 8 cycles, so 30 covers the lag
	task run_case(input [31:0] c);
		axi_wr(5'h00, {28'h0, c[31:28]});
		host_u.set_contacts(c[26], c[25], c[24]);
		repeat (30) @(posedge i_clk);
		check("outs", {11'h0, c[20:0]}, {11'h0, o_preset_active, o_speed_reverse,
			o_pi_to_p, o_fwd_tlim_en, o_rev_tlim_en, o_speed_ref});
	endtask
	task give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		{failures, compares, steps, cyc} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
		i_srst = 1'b1;
		repeat (4) @(posedge i_clk);
		i_srst <= 1'b0;
		for (i = 0; i < 6; i = i + 1) begin
			axi_rd({i[2:0], 2'b00});
			check("reset", defs[i], rd);
		end
		axi_rd(5'h02);
		check("resp", 32'h2, {30'h0, rs});
		axi_wr(5'h02, 32'h0);
		check("bresp", 32'h2, {30'h0, ws});
		check("nostep", 32'h0, steps);
		$display("test registers done");
		// ratios kept reduced and within range
		for (i = 0; i < 3; i = i + 1) begin
			axi_wr(5'h04, {24'h0, gear[i][31:24]});
			axi_wr(5'h08, {24'h0, gear[i][23:16]});
			steps = 0;
			host_u.send_pulses(gear[i][15:8], 12);
			repeat (10) @(posedge i_clk);
			check("steps", {24'h0, gear[i][7:0]}, steps);
		end
		axi_wr(5'h04, 32'h0);
		axi_rd(5'h04);
		check("num", 32'h1, rd);
		check("bresp0", 32'h0, {30'h0, ws});
		$display("test gear done");
		axi_wr(5'h14, 32'h2ee0);
		for (i = 0; i < 5; i = i + 1)
			run_case(cs[i]);
		for (i = 3; i < 7; i = i + 1) begin
			run_case({i[3:0], 28'h0});
			check("fallbck", i - 3, {30'h0, o_fallback_mode});
		end
		axi_wr(5'h18, 32'h27100001);
		run_case(32'h31010000);
		axi_wr(5'h18, 32'h27100011);
		run_case(32'h31100064);
		$display("test contacts done");
		give_verdict;
	end
endmodule
